/* File: pse_cmd_defines.svh */
/*
  constants for the push-button command block: command codes, field
  positions, class limits and fault code.
  assumes it is included by bare name from the design.
*/
`ifndef PSE_CMD_DEFINES_SVH
`define PSE_CMD_DEFINES_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CODE_RESTART_CMD 8'h18
`define CODE_POWER_CMD 8'h19
`define READ_VALUE_CMD 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ON_BITS_LSB 0
`define OFF_BITS_LSB 4
`define DET_BITS_LSB 0
`define CLS_BITS_LSB 4

// ----------------------------------------------------------------------
// class limit and fault code
// ----------------------------------------------------------------------
`define SINGLE_PAIR_MAX_CLASS 4'h4
`define INSUFFICIENT_POWER_CODE 4'h1

`endif

/* File: pse_cmd_pkg.sv */
/*
  types for the push-button command block.
  assumes nothing beyond the defines header.
*/
package pse_cmd_pkg;

  // ----------------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_MANUAL = 2'b01,
    MODE_SEMI = 2'b10,
    MODE_AUTO = 2'b11
  } mode_t;

endpackage : pse_cmd_pkg

/* File: pse_pushbutton_channel_commands.sv */
/*
  push-button restart and power commands for one group of four channels.
  assumes decoded register writes and reads arrive as one-cycle strobes
  synchronous to mclk_in, and channel state comes from the channel logic.
*/
// Functional notes
// - restart code takes one byte; a one launches, a zero does nothing
// - restart bits 7-4 restart class, bits 3-0 restart detection
// - manual runs one cycle; semi auto sets the channel enable bit
// - reading the restart command register always returns zero
// - restart during cool-down is kept and acted on afterwards
// - 4-pair port in semi or auto needs both channel bits set
// - power code byte turns channels on or off except in off mode
// - power bits 7-4 turn channels off, bits 3-0 turn them on
// - off and on together on one channel turns it off
// - turn-on during cool-down or disconnect is dropped
// - semi auto with both enables allows a single channel turn-on
// - single signature class 5-8 single turn-on gives start fault
// - class 4 or lower single turn-on powers only that pair set, except in auto where it does nothing
// - secondary of powered single signature turns on at once
// - dual signature second channel uses partner class and allocation
// - manual turn-on powers the channel at once
// - semi auto turn-on tries once; invalid result is not retried
// - turn-off disables at once and clears only that channel
// - semi auto with both enables waits for next cycle, auto does nothing, else one full cycle
`include "pse_cmd_defines.svh"

module pse_pushbutton_channel_commands
  import pse_cmd_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [2*NUM_CH-1:0] ch_mode_in,
  input wire logic [NUM_CH-1:0] cooldown_in,
  input wire logic [NUM_CH-1:0] disconnect_in,
  input wire logic [NUM_CH/2-1:0] four_pair_in,
  input wire logic [NUM_CH/2-1:0] single_sig_in,
  input wire logic [NUM_CH-1:0] powered_in,
  input wire logic [NUM_CH-1:0] det_enable_in,
  input wire logic [NUM_CH-1:0] cls_enable_in,
  input wire logic [4*NUM_CH-1:0] assigned_class_in,
  input wire logic [7:0] power_alloc_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic [NUM_CH-1:0] detect_cycle_out,
  output logic [NUM_CH-1:0] class_cycle_out,
  output logic [NUM_CH-1:0] det_enable_set_out,
  output logic [NUM_CH-1:0] cls_enable_set_out,
  output logic [NUM_CH-1:0] power_on_now_out,
  output logic [NUM_CH-1:0] attempt_full_out,
  output logic [NUM_CH-1:0] attempt_after_out,
  output logic [NUM_CH-1:0] attempt_inherit_out,
  output logic [NUM_CH-1:0] power_off_out,
  output logic [NUM_CH-1:0] clear_fields_out,
  output logic [NUM_CH-1:0] start_fault_flag_out,
  output logic [3:0] fault_code_out,
  output logic [7:0] alloc_snapshot_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic mode_t mode_of(input logic [2*NUM_CH-1:0] m,
                                    input int ch);
    mode_of = mode_t'(m[2*ch +: 2]);
  endfunction : mode_of

  function automatic int partner_of(input int ch);
    partner_of = ch ^ 1;
  endfunction : partner_of

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [NUM_CH-1:0] pend_det_r, pend_det_nxt;
  logic [NUM_CH-1:0] pend_cls_r, pend_cls_nxt;
  logic [7:0] rd_data_nxt;
  logic rd_valid_nxt;
  logic [NUM_CH-1:0] det_cyc_nxt, cls_cyc_nxt, det_set_nxt, cls_set_nxt;
  logic [NUM_CH-1:0] on_now_nxt, att_full_nxt, att_after_nxt;
  logic [NUM_CH-1:0] att_inh_nxt, off_nxt, clr_nxt, start_fault_flag_nxt;
  logic [3:0] fault_code_nxt;
  logic [7:0] alloc_nxt;
  logic restart_wr, power_wr;

  assign restart_wr = wr_strobe_in && (cmd_code_in == `CODE_RESTART_CMD);
  assign power_wr = wr_strobe_in && (cmd_code_in == `CODE_POWER_CMD);

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    int p;
    logic fp, ss, onb, offb, onb_p, rel_det, rel_cls;
    mode_t md;
    p = 0;
    fp = 1'b0;
    ss = 1'b0;
    onb = 1'b0;
    offb = 1'b0;
    onb_p = 1'b0;
    rel_det = 1'b0;
    rel_cls = 1'b0;
    md = MODE_OFF;
    pend_det_nxt = pend_det_r;
    pend_cls_nxt = pend_cls_r;
    rd_data_nxt = `READ_VALUE_CMD;
    rd_valid_nxt = rd_strobe_in;
    det_cyc_nxt = '0;
    cls_cyc_nxt = '0;
    det_set_nxt = '0;
    cls_set_nxt = '0;
    on_now_nxt = '0;
    att_full_nxt = '0;
    att_after_nxt = '0;
    att_inh_nxt = '0;
    off_nxt = '0;
    clr_nxt = '0;
    start_fault_flag_nxt = '0;
    fault_code_nxt = fault_code_out;
    alloc_nxt = alloc_snapshot_out;
    for (int i = 0; i < NUM_CH; i++) begin
      p = partner_of(i);
      md = mode_of(ch_mode_in, i);
      fp = four_pair_in[i/2];
      ss = single_sig_in[i/2];
      // release held restarts once cool-down ends
      if (!cooldown_in[i]) begin
        if (md == MODE_MANUAL) begin
          rel_det = pend_det_r[i];
          rel_cls = pend_cls_r[i];
          det_cyc_nxt[i] = rel_det;
          cls_cyc_nxt[i] = rel_cls;
        end else if (md != MODE_OFF) begin
          rel_det = pend_det_r[i] && (!fp || (pend_det_r[p] &&
                    !cooldown_in[p]));
          rel_cls = pend_cls_r[i] && (!fp || (pend_cls_r[p] &&
                    !cooldown_in[p]));
          det_set_nxt[i] = rel_det;
          cls_set_nxt[i] = rel_cls;
        end else begin
          rel_det = pend_det_r[i];
          rel_cls = pend_cls_r[i];
        end
      end else begin
        rel_det = 1'b0;
        rel_cls = 1'b0;
      end
      // a one launches, new request wins over release
      pend_det_nxt[i] = (pend_det_r[i] && !rel_det) ||
                        (restart_wr && wr_data_in[`DET_BITS_LSB + i]);
      pend_cls_nxt[i] = (pend_cls_r[i] && !rel_cls) ||
                        (restart_wr && wr_data_in[`CLS_BITS_LSB + i]);
      onb = wr_data_in[`ON_BITS_LSB + i];
      offb = wr_data_in[`OFF_BITS_LSB + i];
      onb_p = wr_data_in[`ON_BITS_LSB + p];
      // power byte ignored in off mode
      if (power_wr && md != MODE_OFF) begin
        if (offb) begin
          // off wins; disable and clear this channel only
          off_nxt[i] = 1'b1;
          clr_nxt[i] = 1'b1;
          pend_det_nxt[i] = 1'b0;
          pend_cls_nxt[i] = 1'b0;
        end else if (onb && !cooldown_in[i] && !disconnect_in[i]) begin
          alloc_nxt = power_alloc_in;
          if (md == MODE_MANUAL) begin
            on_now_nxt[i] = 1'b1;
          end else if (fp && ss && powered_in[p]) begin
            on_now_nxt[i] = 1'b1;
          end else if (fp && ss && !onb_p && assigned_class_in[4*i +: 4] >
                       `SINGLE_PAIR_MAX_CLASS) begin
            start_fault_flag_nxt[i] = 1'b1;
            fault_code_nxt = `INSUFFICIENT_POWER_CODE;
          end else if (fp && !ss && powered_in[p]) begin
            att_inh_nxt[i] = 1'b1;
          end else if (md == MODE_AUTO && (fp && !onb_p)) begin
            att_full_nxt[i] = 1'b0;
          end else if (det_enable_in[i] && cls_enable_in[i]) begin
            // semi auto waits for the next detect and class cycle; auto does nothing
            att_after_nxt[i] = (md == MODE_SEMI);
          end else begin
            // one full attempt on this pair set only
            att_full_nxt[i] = 1'b1;
          end
        end
        // cool-down or disconnect drops the turn-on
      end
      if (md == MODE_OFF) begin
        pend_det_nxt[i] = 1'b0;
        pend_cls_nxt[i] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_det_r <= '0;
      pend_cls_r <= '0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      detect_cycle_out <= '0;
      class_cycle_out <= '0;
      det_enable_set_out <= '0;
      cls_enable_set_out <= '0;
      power_on_now_out <= '0;
      attempt_full_out <= '0;
      attempt_after_out <= '0;
      attempt_inherit_out <= '0;
      power_off_out <= '0;
      clear_fields_out <= '0;
      start_fault_flag_out <= '0;
      fault_code_out <= 4'h0;
      alloc_snapshot_out <= 8'h00;
    end else begin
      pend_det_r <= pend_det_nxt;
      pend_cls_r <= pend_cls_nxt;
      rd_data_out <= rd_data_nxt;
      rd_valid_out <= rd_valid_nxt;
      detect_cycle_out <= det_cyc_nxt;
      class_cycle_out <= cls_cyc_nxt;
      det_enable_set_out <= det_set_nxt;
      cls_enable_set_out <= cls_set_nxt;
      power_on_now_out <= on_now_nxt;
      attempt_full_out <= att_full_nxt;
      attempt_after_out <= att_after_nxt;
      attempt_inherit_out <= att_inh_nxt;
      power_off_out <= off_nxt;
      clear_fields_out <= clr_nxt;
      start_fault_flag_out <= start_fault_flag_nxt;
      fault_code_out <= fault_code_nxt;
      alloc_snapshot_out <= alloc_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // checks on channel zero
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  logic manual0, off0;
  assign manual0 = mode_of(ch_mode_in, 0) == MODE_MANUAL;
  assign off0 = mode_of(ch_mode_in, 0) == MODE_OFF;

  sequence s_restart_manual0;
    restart_wr && wr_data_in[0] && manual0 && !cooldown_in[0];
  endsequence

  sequence s_held_free0;
    manual0 && !cooldown_in[0];
  endsequence

  a_read_zero: assert property (
    rd_strobe_in |=> rd_valid_out && rd_data_out == 8'h00)
    else $error("restart read not zero");

  a_manual_restart: assert property (
    s_restart_manual0 ##1 s_held_free0 |=> detect_cycle_out[0])
    else $error("manual restart did not run a cycle");

  a_cool_hold: assert property (
    pend_det_r[0] && cooldown_in[0] && !off0 &&
    !(power_wr && wr_data_in[4]) |=> !detect_cycle_out[0] &&
    pend_det_r[0])
    else $error("restart acted during cool-down");

  a_pulse_once: assert property (
    detect_cycle_out[0] && !$past(restart_wr) |=> !detect_cycle_out[0])
    else $error("restart pulse stretched");

  a_off_wins: assert property (
    power_wr && !off0 && wr_data_in[4] && wr_data_in[0] |=>
    power_off_out[0] && clear_fields_out[0] && !power_on_now_out[0])
    else $error("off did not win over on");

  a_off_mode_ignore: assert property (
    power_wr && off0 |=> !power_off_out[0] && !power_on_now_out[0])
    else $error("power command acted in off mode");

  a_cool_discard: assert property (
    power_wr && wr_data_in[0] && (cooldown_in[0] || disconnect_in[0]) |=>
    !power_on_now_out[0] && !attempt_full_out[0] && !attempt_after_out[0])
    else $error("turn-on taken during cool-down");

  a_manual_on: assert property (
    power_wr && manual0 && wr_data_in[0] && !wr_data_in[4] &&
    !cooldown_in[0] && !disconnect_in[0] |=> power_on_now_out[0])
    else $error("manual turn-on not immediate");

  a_start_fault_flag_code: assert property (
    start_fault_flag_out[0] |-> fault_code_out == 4'h1)
    else $error("start fault without power code");

endmodule : pse_pushbutton_channel_commands

/* File: host_model.sv */
/*
  host model: issues command writes and reads toward the block.
  assumes it shares mclk_in with the block and drives on falling edges.
*/
module host_model (
  input wire logic mclk_in,
  output logic wr_strobe_out,
  output logic rd_strobe_out,
  output logic [7:0] code_out,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_strobe_out = 1'b0;
    rd_strobe_out = 1'b0;
    code_out = 8'h00;
    data_out = 8'h00;
  end

  // ----------------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------------
  // whole byte, allocation set beforehand
  task write_cmd(input logic [7:0] c, input logic [7:0] d);
    @(negedge mclk_in);
    code_out = c;
    data_out = d;
    wr_strobe_out = 1'b1;
    @(negedge mclk_in);
    wr_strobe_out = 1'b0;
    code_out = ~c;
    data_out = ~d;
  endtask : write_cmd

  task read_cmd(input logic [7:0] c);
    @(negedge mclk_in);
    code_out = c;
    rd_strobe_out = 1'b1;
    @(negedge mclk_in);
    rd_strobe_out = 1'b0;
    code_out = ~c;
  endtask : read_cmd
endmodule : host_model

/* File: tb.sv */
/*
  testbench for the push-button command block.
  assumes host_model drives the register port; channel state from here.
*/
module tb import pse_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr, rd;
  logic [7:0] code, data, rdat, snap;
  logic [7:0] mode = 8'h00;
  logic [3:0] cool = 4'h0, disc = 4'h0, pwr = 4'h0;
  logic [3:0] den = 4'h0, cen = 4'h0, fcode;
  logic [1:0] fp = 2'b00, ss = 2'b00;
  logic [15:0] cls = 16'h0000;
  logic [7:0] alloc = 8'h00;
  logic rvalid;
  wire [3:0] p [0:10];
  logic [3:0] acc [0:10];
  int n_fail = 0;
  int checks = 0;

  initial begin
    forever #4 mclk_in = ~mclk_in;
  end

  host_model host (.mclk_in(mclk_in), .wr_strobe_out(wr),
    .rd_strobe_out(rd), .code_out(code), .data_out(data));

  pse_pushbutton_channel_commands #(.NUM_CH(4)) DUT (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .wr_strobe_in(wr),
    .rd_strobe_in(rd), .cmd_code_in(code), .wr_data_in(data),
    .ch_mode_in(mode), .cooldown_in(cool), .disconnect_in(disc),
    .four_pair_in(fp), .single_sig_in(ss), .powered_in(pwr),
    .det_enable_in(den), .cls_enable_in(cen), .assigned_class_in(cls),
    .power_alloc_in(alloc), .rd_data_out(rdat), .rd_valid_out(rvalid),
    .detect_cycle_out(p[10]), .class_cycle_out(p[9]),
    .det_enable_set_out(p[8]), .cls_enable_set_out(p[7]),
    .power_on_now_out(p[6]), .attempt_full_out(p[5]),
    .attempt_after_out(p[4]), .attempt_inherit_out(p[3]),
    .power_off_out(p[2]), .clear_fields_out(p[1]),
    .start_fault_flag_out(p[0]), .fault_code_out(fcode),
    .alloc_snapshot_out(snap));

  // collects every pulse seen since the last clear
  always @(posedge mclk_in) begin
    for (int k = 0; k < 11; k++) begin
      acc[k] <= acc[k] | p[k];
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task clear_acc;
    for (int k = 0; k < 11; k++) begin
      acc[k] = 4'h0;
    end
  endtask : clear_acc

  task settle_chk(input logic [43:0] e);
    repeat (5) @(negedge mclk_in);
    for (int k = 0; k < 11; k++) begin
      chk($sformatf("pulse group %0d", k), e[k*4+:4], acc[k]);
    end
  endtask : settle_chk

  task op(input logic [7:0] c, input logic [7:0] d, input logic [43:0] e);
    clear_acc();
    host.write_cmd(c, d);
    settle_chk(e);
  endtask : op

  task rd_chk;
    host.read_cmd(8'h18);
    chk("read valid", 16'h0001, rvalid);
    chk("read data", 16'h0000, rdat);
  endtask : rd_chk

  task complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    #30000;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    clear_acc();
    repeat (20) @(negedge mclk_in);
    reset_n_in = 1'b1;
    rd_chk();
    mode = {4{MODE_MANUAL}};
    op(8'h18, 8'hff, 44'hff000000000);
    rd_chk();
    op(8'h18, 8'h00, 44'h0);
    mode = {4{MODE_SEMI}};
    op(8'h18, 8'h21, 44'h00120000000);
    mode = {4{MODE_MANUAL}};
    cool = 4'h5;
    op(8'h18, 8'h05, 44'h0);
    clear_acc();
    cool = 4'h0;
    settle_chk(44'h50000000000);
    mode = {4{MODE_SEMI}};
    fp = 2'b01;
    op(8'h18, 8'h01, 44'h0);
    op(8'h18, 8'h02, 44'h00300000000);
    fp = 2'b00;
    mode = {4{MODE_MANUAL}};
    op(8'h19, 8'h0f, 44'h0000f000000);
    op(8'h19, 8'hf0, 44'h00000000ff0);
    op(8'h19, 8'h22, 44'h00000000220);
    mode = {4{MODE_OFF}};
    op(8'h19, 8'hff, 44'h0);
    mode = {4{MODE_MANUAL}};
    cool = 4'h1;
    disc = 4'h2;
    op(8'h19, 8'h03, 44'h0);
    cool = 4'h0;
    disc = 4'h0;
    mode = {4{MODE_SEMI}};
    op(8'h19, 8'h01, 44'h00000100000);
    op(8'h19, 8'h01, 44'h00000100000);
    den = 4'hf;
    cen = 4'hf;
    fp = 2'b01;
    op(8'h19, 8'h01, 44'h00000010000);
    fp = 2'b10;
    ss = 2'b10;
    cls = 16'h5500;
    clear_acc();
    host.write_cmd(8'h19, 8'h04);
    repeat (5) @(negedge mclk_in);
    chk("start fault", 16'h0004, acc[0]);
    chk("fault code", 16'h0001, fcode);
    cls = 16'h4400;
    clear_acc();
    host.write_cmd(8'h19, 8'h04);
    repeat (5) @(negedge mclk_in);
    chk("single pair", 16'h0004, acc[4]);
    chk("no fault", 16'h0000, acc[0]);
    pwr = 4'h4;
    op(8'h19, 8'h08, 44'h00008000000);
    ss = 2'b00;
    alloc = 8'h5a;
    op(8'h19, 8'h08, 44'h00000008000);
    chk("alloc snapshot", 16'h005a, snap);
    alloc = 8'h33;
    repeat (3) @(negedge mclk_in);
    chk("alloc held", 16'h005a, snap);
    mode = {4{MODE_AUTO}};
    op(8'h19, 8'h01, 44'h0);
    op(8'h19, 8'h04, 44'h0);
    den = 4'h0;
    cen = 4'h0;
    op(8'h19, 8'h01, 44'h00000100000);
    op(8'h18, 8'h10, 44'h00010000000);
    complete_run();
  end
endmodule : tb
